/* verilog/hfs_pkg.sv */
// Package: register map, field layout, reset values and carriers for handwheel feed select
`default_nettype none
package hfs_pkg;
  localparam int HFS_HANDLES = 4;
  localparam int HFS_LINK_MODULES = 4;
  localparam int HFS_ADDR_W = 8;
  localparam int HFS_DATA_W = 16;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] HFS_AXIS_SEL_1_2_ADDR = 8'h00;
  localparam logic [7:0] HFS_AXIS_SEL_3_MULT_ADDR = 8'h01;
  localparam logic [7:0] HFS_AXIS_SEL_4_ADDR = 8'h02;
  localparam logic [7:0] HFS_MODE_SELECT_ADDR = 8'h03;
  localparam logic [7:0] HFS_PER_HANDLE_MULT_ADDR = 8'h04;
  localparam logic [7:0] HFS_MULT_CONFIG_ADDR = 8'h05;
  localparam logic [7:0] HFS_DIRECTION_CONFIG_ADDR = 8'h06;
  localparam logic [7:0] HFS_HANDLE_COUNT_ADDR = 8'h07;
  localparam logic [7:0] HFS_MAG_M_BASE_ADDR = 8'h08;
  localparam logic [7:0] HFS_MAG_N_BASE_ADDR = 8'h0C;
  localparam logic [7:0] HFS_LINK_ALLOC_ADDR = 8'h10;
  localparam logic [7:0] HFS_STATUS_ADDR = 8'h11;
  localparam logic [7:0] HFS_COUNT_BASE_ADDR = 8'h12;
  localparam logic [7:0] HFS_FEED_STYLE_ADDR = 8'h16;
  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int HFS_COMMON_MULT_LSB = 4;
  localparam int HFS_MULT_ENABLE_BIT = 5;
  localparam int HFS_LINK_USE_LSB = 4;
  localparam logic [2:0] HFS_MODE_HANDLE = 3'h4;
  localparam logic [3:0] HFS_AXIS_NONE = 4'h0;
  localparam logic [3:0] HFS_AXIS_LAST = 4'h8;
  localparam logic [3:0] HFS_AXIS_GUIDE = 4'hE;
  localparam logic [3:0] HFS_AXIS_APPROACH = 4'hF;
  localparam logic [3:0] HFS_SERVO_READY = 4'h0;
  localparam logic [6:0] HFS_M_MAX = 7'h7F;
  localparam logic [9:0] HFS_N_MAX = 10'h3E8;
  localparam logic [1:0] HFS_MULT_X1 = 2'h0;
  localparam logic [1:0] HFS_MULT_X10 = 2'h1;
  localparam logic [1:0] HFS_MULT_M = 2'h2;
  localparam logic [1:0] HFS_MULT_N = 2'h3;
  localparam logic [9:0] HFS_MAG_1 = 10'h001;
  localparam logic [9:0] HFS_MAG_10 = 10'h00A;
  localparam logic [9:0] HFS_MAG_100 = 10'h064;
  localparam logic [9:0] HFS_MAG_1000 = 10'h3E8;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] HFS_HANDLE_COUNT_RESET = 3'h1;
  localparam logic [6:0] HFS_M_RESET = 7'h01;
  localparam logic [9:0] HFS_N_RESET = 10'h001;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic phaseA;
    logic phaseB;
  } hfs_phase_t;
  typedef struct packed {
    logic valid;
    logic [7:0] axisMask;
    logic guide;
    logic approach;
    logic signed [11:0] travel;
  } hfs_move_t;
endpackage
`default_nettype wire

/* verilog/hfs_quad_decoder.sv */
// Quadrature decoder for one handwheel: pin synchroniser and step/direction output
`default_nettype none
module hfs_quad_decoder
  import hfs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire hfs_phase_t phaseIn,
  output logic stepPulse,
  output logic stepUp
);
  hfs_phase_t sync1_reg, sync2_reg, sync3_reg;
  hfs_phase_t stable_reg;
  logic [1:0] nowBits, oldBits;

  // A change counts only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      stable_reg <= '0;
    end else begin
      sync1_reg <= phaseIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        stable_reg <= sync3_reg;
      end
    end
  end

  assign nowBits = {sync3_reg.phaseA, sync3_reg.phaseB};
  assign oldBits = {stable_reg.phaseA, stable_reg.phaseB};

  // Direction from the phase lead; a double jump is dropped as noise
  always_comb begin
    stepPulse = 1'b0;
    stepUp = 1'b0;
    if (sync2_reg == sync3_reg && nowBits != oldBits && (nowBits ^ oldBits) != 2'h3) begin
      stepPulse = 1'b1;
      stepUp = (oldBits[1] ^ nowBits[0]);
    end
  end
endmodule
`default_nettype wire

/* verilog/hfs_magnifier.sv */
// Travel-per-step magnification for one handwheel
`default_nettype none
module hfs_magnifier
  import hfs_pkg::*;
(
  input wire logic [1:0] multCode,
  input wire logic stepFeed,
  input wire logic [6:0] magM,
  input wire logic [9:0] magN,
  output logic [9:0] magnitude
);
  always_comb begin
    unique case (multCode)
      HFS_MULT_X1: magnitude = HFS_MAG_1;
      HFS_MULT_X10: magnitude = HFS_MAG_10;
      HFS_MULT_M: magnitude = stepFeed ? HFS_MAG_100 : {3'h0, magM};
      HFS_MULT_N: magnitude = stepFeed ? HFS_MAG_1000 : magN;
    endcase
  end
endmodule
`default_nettype wire

/* verilog/hfs_handwheel_feed.sv */
// Handwheel feed select: registers, link module choice, axis decode and travel scaling
`default_nettype none
// Behaviour
// - Handle mode only on mode code 100
// - Axis codes 0 none, 1-8 axes
// - Codes 1110/1111 move X and Y together
// - Three handwheels; fourth only on extended variant
// - Multiplier code scales travel per step
// - Common or per-handle multiplier code selection
// - Magnifications M 1-127, N 1-1000 per handle
// - Direction bit reverses travel sign
// - Handwheel count 1-4, four only extended
// - Nearest allocated handwheel module takes pulses
// - Skip nearer module allocated without handwheel use
// - Count pulses up or down with rotation
// - No motion unless servo status code zero
module hfs_handwheel_feed
  import hfs_pkg::*;
#(
  parameter bit EXTENDED = 1'b0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [HFS_ADDR_W-1:0] regAddr,
  input wire logic [HFS_DATA_W-1:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [HFS_DATA_W-1:0] regReadData,
  input wire hfs_phase_t [HFS_LINK_MODULES*HFS_HANDLES-1:0] linkPhases,
  input wire logic [3:0] servoStatusCode,
  output logic handleModeStatus,
  output logic motionReject,
  output hfs_move_t [HFS_HANDLES-1:0] moveOut
);
  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0] axisSel12_reg, axisSel3Mult_reg, axisSel4_reg, modeSelect_reg;
  logic [7:0] perHandleMult_reg, multConfig_reg, directionConfig_reg;
  logic [2:0] handleCount_reg;
  logic [6:0] magM_reg [HFS_HANDLES];
  logic [9:0] magN_reg [HFS_HANDLES];
  logic [7:0] linkAlloc_reg;
  logic feedStyle_reg;
  logic signed [15:0] pulseCount_reg [HFS_HANDLES];
  logic [HFS_DATA_W-1:0] readData_reg;
  logic [2:0] maxHandles;
  logic [1:0] regSlot;
  logic [2:0] writeCount;

  assign maxHandles = EXTENDED ? 3'h4 : 3'h3;
  assign regSlot = regAddr[1:0];
  assign writeCount = regWriteData[2:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      axisSel12_reg <= 8'h00;
      axisSel3Mult_reg <= 8'h00;
      axisSel4_reg <= 8'h00;
      modeSelect_reg <= 8'h00;
      perHandleMult_reg <= 8'h00;
      multConfig_reg <= 8'h00;
      directionConfig_reg <= 8'h00;
      handleCount_reg <= HFS_HANDLE_COUNT_RESET;
      linkAlloc_reg <= 8'h00;
      feedStyle_reg <= 1'b0;
    end else if (regWrite) begin
      unique case (regAddr)
        HFS_AXIS_SEL_1_2_ADDR: axisSel12_reg <= regWriteData[7:0];
        HFS_AXIS_SEL_3_MULT_ADDR: axisSel3Mult_reg <= regWriteData[7:0];
        HFS_AXIS_SEL_4_ADDR: begin
          if (EXTENDED) begin
            axisSel4_reg <= regWriteData[7:0];
          end
        end
        HFS_MODE_SELECT_ADDR: modeSelect_reg <= regWriteData[7:0];
        HFS_PER_HANDLE_MULT_ADDR: perHandleMult_reg <= regWriteData[7:0];
        HFS_MULT_CONFIG_ADDR: multConfig_reg <= regWriteData[7:0];
        HFS_DIRECTION_CONFIG_ADDR: directionConfig_reg <= regWriteData[7:0];
        HFS_HANDLE_COUNT_ADDR: begin
          // Out-of-range counts are ignored, keeping the last legal value
          if (writeCount != 3'h0 && writeCount <= maxHandles) begin
            handleCount_reg <= writeCount;
          end
        end
        HFS_LINK_ALLOC_ADDR: linkAlloc_reg <= regWriteData[7:0];
        HFS_FEED_STYLE_ADDR: feedStyle_reg <= regWriteData[0];
        default: ;
      endcase
    end
  end

  // Magnifications keep their old value when a write is out of range
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < HFS_HANDLES; i++) begin
        magM_reg[i] <= HFS_M_RESET;
        magN_reg[i] <= HFS_N_RESET;
      end
    end else if (regWrite) begin
      if (regAddr[7:2] == HFS_MAG_M_BASE_ADDR[7:2]) begin
        if (regWriteData[6:0] != 7'h00 && regWriteData[15:7] == 9'h000) begin
          magM_reg[regSlot] <= regWriteData[6:0];
        end
      end
      if (regAddr[7:2] == HFS_MAG_N_BASE_ADDR[7:2]) begin
        if (regWriteData[9:0] != 10'h000 && regWriteData[9:0] <= HFS_N_MAX
            && regWriteData[15:10] == 6'h00) begin
          magN_reg[regSlot] <= regWriteData[9:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode and servo gating
  // ----------------------------------------------------------------
  logic servoActive;
  logic handleMode;

  assign handleMode = (modeSelect_reg[2:0] == HFS_MODE_HANDLE);
  assign servoActive = (servoStatusCode == HFS_SERVO_READY);

  always_ff @(posedge clk) begin
    if (reset) begin
      handleModeStatus <= 1'b0;
      motionReject <= 1'b0;
    end else begin
      handleModeStatus <= handleMode;
      motionReject <= handleMode && !servoActive;
    end
  end

  // ----------------------------------------------------------------
  // Link module choice
  // ----------------------------------------------------------------
  logic [HFS_LINK_MODULES-1:0] moduleUsable;
  logic [1:0] moduleIndex;
  logic moduleFound;

  // Lowest index sits nearest the controller on the link
  assign moduleUsable = linkAlloc_reg[3:0] & linkAlloc_reg[7:HFS_LINK_USE_LSB];

  always_comb begin
    moduleIndex = 2'h0;
    moduleFound = 1'b0;
    for (int m = HFS_LINK_MODULES - 1; m >= 0; m--) begin
      if (moduleUsable[m]) begin
        moduleIndex = 2'(m);
        moduleFound = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-handle selection, decode and travel
  // ----------------------------------------------------------------
  logic [3:0] axisCode [HFS_HANDLES];
  logic [1:0] multCode [HFS_HANDLES];
  logic [HFS_HANDLES-1:0] stepPulse, stepUp, handleLive;
  logic [9:0] magnitude [HFS_HANDLES];

  assign axisCode[0] = axisSel12_reg[3:0];
  assign axisCode[1] = axisSel12_reg[7:4];
  assign axisCode[2] = axisSel3Mult_reg[3:0];
  assign axisCode[3] = axisSel4_reg[3:0];

  // Handle one always follows the common code
  assign multCode[0] = axisSel3Mult_reg[HFS_COMMON_MULT_LSB +: 2];
  assign multCode[1] = multConfig_reg[HFS_MULT_ENABLE_BIT] ? perHandleMult_reg[1:0]
                                                           : multCode[0];
  assign multCode[2] = multConfig_reg[HFS_MULT_ENABLE_BIT] ? perHandleMult_reg[4:3]
                                                           : multCode[0];
  assign multCode[3] = multConfig_reg[HFS_MULT_ENABLE_BIT] ? perHandleMult_reg[7:6]
                                                           : multCode[0];

  for (genvar h = 0; h < HFS_HANDLES; h++) begin : gHandle
    hfs_phase_t chosenPhase;
    logic signed [11:0] signedTravel;
    logic [7:0] axisMask;
    logic guideCode, approachCode, codeValid;

    assign chosenPhase = moduleFound ? linkPhases[moduleIndex * HFS_HANDLES + h] : '0;

    hfs_quad_decoder uDecoder (
      .clk(clk),
      .reset(reset),
      .phaseIn(chosenPhase),
      .stepPulse(stepPulse[h]),
      .stepUp(stepUp[h])
    );

    hfs_magnifier uMagnifier (
      .multCode(multCode[h]),
      .stepFeed(feedStyle_reg),
      .magM(magM_reg[h]),
      .magN(magN_reg[h]),
      .magnitude(magnitude[h])
    );

    assign guideCode = (axisCode[h] == HFS_AXIS_GUIDE);
    assign approachCode = (axisCode[h] == HFS_AXIS_APPROACH);
    // Codes 1001 to 1101 select nothing
    assign codeValid = (axisCode[h] != HFS_AXIS_NONE && axisCode[h] <= HFS_AXIS_LAST)
                       || guideCode || approachCode;
    assign axisMask = (guideCode || approachCode) ? 8'h03 :
                      codeValid ? 8'(8'h01 << (axisCode[h] - 4'h1)) : 8'h00;

    assign handleLive[h] = handleMode && servoActive && codeValid
                           && (3'(h) < handleCount_reg) && (h < 3 || EXTENDED);

    // Sign follows rotation unless the handle's reverse bit is set
    assign signedTravel = ((stepUp[h] ^ directionConfig_reg[h]) ?
                           $signed({2'b00, magnitude[h]}) :
                           -$signed({2'b00, magnitude[h]}));

    always_ff @(posedge clk) begin
      if (reset) begin
        moveOut[h] <= '0;
      end else begin
        moveOut[h].valid <= stepPulse[h] && handleLive[h];
        if (stepPulse[h] && handleLive[h]) begin
          moveOut[h].axisMask <= axisMask;
          moveOut[h].guide <= guideCode;
          moveOut[h].approach <= approachCode;
          moveOut[h].travel <= signedTravel;
        end
      end
    end

    // Raw count mirrors the input-area counter, whatever the mode
    always_ff @(posedge clk) begin
      if (reset) begin
        pulseCount_reg[h] <= 16'sh0000;
      end else if (stepPulse[h]) begin
        pulseCount_reg[h] <= stepUp[h] ? pulseCount_reg[h] + 16'sh0001
                                       : pulseCount_reg[h] - 16'sh0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [HFS_DATA_W-1:0] readValue;

  always_comb begin
    readValue = '0;
    if (regAddr[7:2] == HFS_MAG_M_BASE_ADDR[7:2]) begin
      readValue = {9'h000, magM_reg[regSlot]};
    end else if (regAddr[7:2] == HFS_MAG_N_BASE_ADDR[7:2]) begin
      readValue = {6'h00, magN_reg[regSlot]};
    end else if (regAddr >= HFS_COUNT_BASE_ADDR && regAddr < HFS_FEED_STYLE_ADDR) begin
      readValue = pulseCount_reg[2'(regAddr - HFS_COUNT_BASE_ADDR)];
    end else begin
      unique case (regAddr)
        HFS_AXIS_SEL_1_2_ADDR: readValue = {8'h00, axisSel12_reg};
        HFS_AXIS_SEL_3_MULT_ADDR: readValue = {8'h00, axisSel3Mult_reg};
        HFS_AXIS_SEL_4_ADDR: readValue = {8'h00, axisSel4_reg};
        HFS_MODE_SELECT_ADDR: readValue = {8'h00, modeSelect_reg};
        HFS_PER_HANDLE_MULT_ADDR: readValue = {8'h00, perHandleMult_reg};
        HFS_MULT_CONFIG_ADDR: readValue = {8'h00, multConfig_reg};
        HFS_DIRECTION_CONFIG_ADDR: readValue = {8'h00, directionConfig_reg};
        HFS_HANDLE_COUNT_ADDR: readValue = {13'h0000, handleCount_reg};
        HFS_LINK_ALLOC_ADDR: readValue = {8'h00, linkAlloc_reg};
        HFS_STATUS_ADDR: readValue = {12'h000, moduleIndex, servoActive, handleMode};
        HFS_FEED_STYLE_ADDR: readValue = {15'h0000, feedStyle_reg};
        default: readValue = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readData_reg <= '0;
    end else if (regRead) begin
      readData_reg <= readValue;
    end else begin
      readData_reg <= '0;
    end
  end

  assign regReadData = readData_reg;
endmodule
`default_nettype wire

/* bench/hfs_handwheel_feed_sva.sv */
// Checker: port-level properties of the handwheel feed select block
`default_nettype none
module hfs_handwheel_feed_chk
  import hfs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [HFS_ADDR_W-1:0] regAddr,
  input wire logic [HFS_DATA_W-1:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [HFS_DATA_W-1:0] regReadData,
  input wire hfs_phase_t [HFS_LINK_MODULES*HFS_HANDLES-1:0] linkPhases,
  input wire logic [3:0] servoStatusCode,
  input wire logic handleModeStatus,
  input wire logic motionReject,
  input wire hfs_move_t [HFS_HANDLES-1:0] moveOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_mode_wr;
    regWrite && regAddr == HFS_MODE_SELECT_ADDR;
  endsequence
  sequence s_servo_bad;
    (handleModeStatus && servoStatusCode != HFS_SERVO_READY) [*3];
  endsequence
  property p_mode;
    s_mode_wr |-> ##2 handleModeStatus == ($past(regWriteData[2:0], 2) == HFS_MODE_HANDLE);
  endproperty
  property p_reject;
    s_servo_bad |-> motionReject;
  endproperty
  property p_accept;
    (servoStatusCode == HFS_SERVO_READY) [*2] |-> !motionReject;
  endproperty
  property p_no4;
    !moveOut[3].valid;
  endproperty
  property p_pulse(hfs_move_t m);
    m.valid |=> !m.valid;
  endproperty
  property p_gate(hfs_move_t m);
    m.valid |-> handleModeStatus && !motionReject && $past(servoStatusCode) == HFS_SERVO_READY;
  endproperty
  property p_xy(hfs_move_t m);
    m.valid && (m.guide || m.approach) |-> m.axisMask == 8'h03 && !(m.guide && m.approach);
  endproperty
  property p_axis(hfs_move_t m);
    m.valid && !m.guide && !m.approach |-> $onehot(m.axisMask);
  endproperty
  property p_travel(hfs_move_t m);
    m.valid |-> m.travel != 0 && m.travel <= 12'sd1000 && m.travel >= -12'sd1000;
  endproperty
  a_mode: assert property (p_mode) else $error("mode status wrong");
  a_reject: assert property (p_reject) else $error("reject missing");
  a_accept: assert property (p_accept) else $error("reject with servo ready");
  a_no4: assert property (p_no4) else $error("fourth handle moved");
  for (genvar h = 0; h < HFS_HANDLES; h++) begin : g_h
    a_pulse: assert property (p_pulse(moveOut[h])) else $error("long move pulse");
    a_gate: assert property (p_gate(moveOut[h])) else $error("move not allowed");
    a_xy: assert property (p_xy(moveOut[h])) else $error("guide mask wrong");
    a_axis: assert property (p_axis(moveOut[h])) else $error("axis mask wrong");
    a_travel: assert property (p_travel(moveOut[h])) else $error("travel range");
  end
endmodule
bind hfs_handwheel_feed hfs_handwheel_feed_chk i_chk (.clk(clk), .reset(reset),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
  .regReadData(regReadData), .linkPhases(linkPhases), .servoStatusCode(servoStatusCode),
  .handleModeStatus(handleModeStatus), .motionReject(motionReject), .moveOut(moveOut));
`default_nettype wire

/* bench/hfs_pulse_gen.sv */
// Handwheel pulse generator model: two-phase gray steps on one chosen link slot
`default_nettype none
module hfs_pulse_gen
  import hfs_pkg::*;
(
  input wire logic clk,
  input wire logic stepReq,
  input wire logic stepDir,
  input wire logic [3:0] slot,
  output var hfs_phase_t [15:0] phases
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pos [16] = '{default: 2'h0};
  // One phase edge per step, so no two-bit jump is ever produced
  always @(posedge clk) begin
    if (stepReq) begin
      pos[slot] <= pos[slot] + (stepDir ? 2'h1 : 2'h3);
    end
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      phases[i] = '{phaseA: pos[i][1] ^ pos[i][0], phaseB: pos[i][1]};
    end
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Testbench: directed scenarios for the handwheel feed select block
`default_nettype none
module testbench
  import hfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWriteData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regReadData;
  hfs_phase_t [15:0] linkPhases;
  logic [3:0] servoStatusCode = 4'h0;
  logic handleModeStatus;
  logic motionReject;
  hfs_move_t [3:0] moveOut;
  hfs_move_t got;
  logic stepReq = 1'b0;
  logic stepDir = 1'b1;
  logic [3:0] slot = 4'h0;
  int fail_count = 0;
  int n_checks = 0;
  int nv;
  logic signed [11:0] t1;
  always #5 clk = ~clk;
  hfs_handwheel_feed i_dut (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .linkPhases(linkPhases), .servoStatusCode(servoStatusCode),
    .handleModeStatus(handleModeStatus), .motionReject(motionReject), .moveOut(moveOut));
  hfs_pulse_gen i_gen (.clk(clk), .stepReq(stepReq), .stepDir(stepDir), .slot(slot),
    .phases(linkPhases));
  // ----------------------------------------------------------------
  // Bus, step and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regReadData, e);
  endtask
  // Eight cycles of watching also keeps steps apart for the one-cycle pulse check
  task automatic mv(input int m, h, input logic d, input int ev, input logic [15:0] mag,
      input logic [9:0] gam);
    @(posedge clk);
    slot <= 4'(m * 4 + h);
    stepDir <= d;
    stepReq <= 1'b1;
    @(posedge clk);
    stepReq <= 1'b0;
    nv = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (moveOut[h].valid === 1'b1) begin
        nv++;
        got = moveOut[h];
      end
    end
    chk(16'(nv), 16'(ev));
    if (ev == 1) begin
      chk(16'(got.travel < 0 ? -got.travel : got.travel), mag);
      chk({6'h00, got.guide, got.approach, got.axisMask}, {6'h00, gam});
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(HFS_HANDLE_COUNT_ADDR, 16'h0001);
    rd(8'h08, 16'h0001);
    rd(8'h0C, 16'h0001);
    rd(8'h40, 16'h0000);
    wr(8'h08, 16'h0000);
    rd(8'h08, 16'h0001);
    wr(8'h08, 16'h0080);
    rd(8'h08, 16'h0001);
    wr(8'h08, 16'h007F);
    rd(8'h08, 16'h007F);
    wr(8'h0C, 16'h03E9);
    rd(8'h0C, 16'h0001);
    wr(8'h0C, 16'h03E8);
    rd(8'h0C, 16'h03E8);
    wr(HFS_HANDLE_COUNT_ADDR, 16'h0004);
    rd(HFS_HANDLE_COUNT_ADDR, 16'h0001);
    wr(HFS_HANDLE_COUNT_ADDR, 16'h0003);
    rd(HFS_HANDLE_COUNT_ADDR, 16'h0003);
    wr(HFS_AXIS_SEL_4_ADDR, 16'h0005);
    rd(HFS_AXIS_SEL_4_ADDR, 16'h0000);
    $display("test regs finished");
  endtask
  task automatic t_mode();
    for (int c = 0; c < 8; c++) begin
      wr(HFS_MODE_SELECT_ADDR, 16'(c));
      repeat (2) @(posedge clk);
      #1 chk(16'(handleModeStatus), 16'(c == 4));
    end
    wr(HFS_LINK_ALLOC_ADDR, 16'h0011);
    wr(8'h00, 16'h0021);
    mv(0, 0, 1'b1, 0, 16'd1, 10'h001);
    wr(HFS_MODE_SELECT_ADDR, 16'h0004);
    mv(0, 0, 1'b1, 1, 16'd1, 10'h001);
    $display("test mode finished");
  endtask
  task automatic t_axis();
    for (int c = 0; c < 16; c++) begin
      wr(8'h00, 16'(c));
      mv(0, 0, 1'b1, int'((c > 0 && c < 9) || c > 13), 16'd1,
        c > 13 ? {c == 14, c == 15, 8'h03} : 10'(c > 0 && c < 9) << (c - 1));
    end
    wr(8'h00, 16'h0021);
    $display("test axis finished");
  endtask
  task automatic t_mult();
    logic [15:0] hx [4] = '{16'd1, 16'd10, 16'd5, 16'd1000};
    logic [15:0] sx [4] = '{16'd1, 16'd10, 16'd100, 16'd1000};
    wr(8'h08, 16'h0005);
    wr(8'h0C, 16'h03E8);
    for (int c = 0; c < 4; c++) begin
      wr(8'h01, 16'h0003 | 16'(c << 4));
      mv(0, 0, 1'b1, 1, hx[c], 10'h001);
      wr(HFS_FEED_STYLE_ADDR, 16'h0001);
      mv(0, 0, 1'b1, 1, sx[c], 10'h001);
      wr(HFS_FEED_STYLE_ADDR, 16'h0000);
    end
    wr(8'h09, 16'h0007);
    wr(8'h01, 16'h0023);
    mv(0, 1, 1'b1, 1, 16'd7, 10'h002);
    wr(HFS_MULT_CONFIG_ADDR, 16'h0020);
    wr(HFS_PER_HANDLE_MULT_ADDR, 16'h0001);
    mv(0, 1, 1'b1, 1, 16'd10, 10'h002);
    mv(0, 0, 1'b1, 1, 16'd5, 10'h001);
    wr(HFS_MULT_CONFIG_ADDR, 16'h0000);
    wr(8'h01, 16'h0003);
    $display("test mult finished");
  endtask
  task automatic t_dir();
    mv(0, 0, 1'b1, 1, 16'd1, 10'h001);
    t1 = got.travel;
    wr(HFS_DIRECTION_CONFIG_ADDR, 16'h0001);
    mv(0, 0, 1'b1, 1, 16'd1, 10'h001);
    chk(16'(got.travel), 16'(-t1));
    mv(0, 0, 1'b0, 1, 16'd1, 10'h001);
    chk(16'(got.travel), 16'(t1));
    wr(HFS_DIRECTION_CONFIG_ADDR, 16'h0000);
    mv(0, 0, 1'b0, 1, 16'd1, 10'h001);
    chk(16'(got.travel), 16'(-t1));
    $display("test dir finished");
  endtask
  task automatic t_link();
    // A new source module shows other phase levels, which decode as one step or, on a double jump, none; let it pass
    wr(HFS_LINK_ALLOC_ADDR, 16'h0023);
    repeat (8) @(posedge clk);
    rd(HFS_STATUS_ADDR, 16'h0007);
    mv(0, 0, 1'b1, 0, 16'd1, 10'h001);
    mv(1, 0, 1'b1, 1, 16'd1, 10'h001);
    wr(HFS_LINK_ALLOC_ADDR, 16'h0033);
    repeat (8) @(posedge clk);
    rd(HFS_STATUS_ADDR, 16'h0003);
    mv(1, 0, 1'b1, 0, 16'd1, 10'h001);
    mv(0, 0, 1'b1, 1, 16'd1, 10'h001);
    $display("test link finished");
  endtask
  task automatic t_servo();
    @(posedge clk);
    servoStatusCode <= 4'h3;
    repeat (3) @(posedge clk);
    #1 chk(16'(motionReject), 16'h0001);
    mv(0, 0, 1'b1, 0, 16'd1, 10'h001);
    @(posedge clk);
    servoStatusCode <= 4'h0;
    repeat (3) @(posedge clk);
    #1 chk(16'(motionReject), 16'h0000);
    mv(0, 0, 1'b1, 1, 16'd1, 10'h001);
    $display("test servo finished");
  endtask
  task automatic t_count();
    wr(HFS_HANDLE_COUNT_ADDR, 16'h0001);
    mv(0, 1, 1'b1, 0, 16'd1, 10'h002);
    wr(HFS_HANDLE_COUNT_ADDR, 16'h0003);
    mv(0, 1, 1'b1, 1, 16'd1, 10'h002);
    wr(HFS_AXIS_SEL_4_ADDR, 16'h0001);
    mv(0, 3, 1'b1, 0, 16'd1, 10'h001);
    $display("test count finished");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_mode();
    t_axis();
    t_mult();
    t_dir();
    t_link();
    t_servo();
    t_count();
    test_done();
  end
  // About 620 cycles are needed; the limit leaves ample margin
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
